// *** design/cpuop_pkg.sv ***
// package: opcodes, field layout, widths and packed carriers for the call/unary-op core
`default_nettype none
package cpuop_pkg;
	localparam int unsigned INSN_W = 14;
	localparam int unsigned PC_W = 13;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FADDR_W = 7;
	localparam int unsigned TGT_W = 11;
	localparam int unsigned LATCH_W = 8;
	localparam int unsigned PAGE_HI = 4;
	localparam int unsigned PAGE_LO = 3;
	localparam int unsigned DEST_BIT = 7;

	// opcode decode: upper bits of the 14-bit instruction word
	localparam logic [2:0] CALL_OPC = 3'h4;
	localparam logic [5:0] COMPLEMENT_FILE_OPC = 6'h09;
	localparam logic [5:0] DECREMENT_FILE_OPC = 6'h03;
	localparam logic [5:0] DEC_SKIP_ZERO_OPC = 6'h0B;
	localparam logic [5:0] INC_SKIP_ZERO_OPC = 6'h0F;
	localparam logic [6:0] CLEAR_FILE_OPC = 7'h03;
	localparam logic [6:0] CLEAR_WORKING_OPC = 7'h02;

	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

	typedef enum logic [2:0]
	{
		OP_NONE,
		OP_CALL,
		OP_COMPLEMENT,
		OP_CLEAR_FILE,
		OP_DECREMENT,
		OP_CLEAR_WORKING,
		OP_DEC_SKIP,
		OP_INC_SKIP
	} cpuop_kind_e;

	// decoded instruction fields
	typedef struct packed
	{
		cpuop_kind_e kind;
		logic dest_file;
		logic [FADDR_W-1:0] faddr;
		logic [TGT_W-1:0] target;
	} cpuop_dec_s;

	// file register write request
	typedef struct packed
	{
		logic en;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cpuop_fwr_s;

	// stack push request
	typedef struct packed
	{
		logic en;
		logic [PC_W-1:0] addr;
	} cpuop_push_s;
endpackage : cpuop_pkg
`default_nettype wire

// *** design/cpuop_decode.sv ***
// instruction word decoder for the call and unary file-register operations
`default_nettype none
module cpuop_decode
(
	// instruction word
	input wire logic [cpuop_pkg::INSN_W-1:0] insn_i,
	// decoded fields
	output cpuop_pkg::cpuop_dec_s dec_o
);
	always_comb
	begin
		dec_o.kind = cpuop_pkg::OP_NONE;
		dec_o.dest_file = insn_i[cpuop_pkg::DEST_BIT];
		dec_o.faddr = insn_i[cpuop_pkg::FADDR_W-1:0];
		dec_o.target = insn_i[cpuop_pkg::TGT_W-1:0];
		if (insn_i[cpuop_pkg::INSN_W-1:cpuop_pkg::TGT_W] == cpuop_pkg::CALL_OPC)
			dec_o.kind = cpuop_pkg::OP_CALL;
		else if (insn_i[cpuop_pkg::INSN_W-1:cpuop_pkg::DEST_BIT] == cpuop_pkg::CLEAR_FILE_OPC)
			dec_o.kind = cpuop_pkg::OP_CLEAR_FILE;
		else if (insn_i[cpuop_pkg::INSN_W-1:cpuop_pkg::DEST_BIT]
			== cpuop_pkg::CLEAR_WORKING_OPC)
			dec_o.kind = cpuop_pkg::OP_CLEAR_WORKING;
		else
		begin
			case (insn_i[cpuop_pkg::INSN_W-1:cpuop_pkg::DEST_BIT+1])
				cpuop_pkg::COMPLEMENT_FILE_OPC: dec_o.kind = cpuop_pkg::OP_COMPLEMENT;
				cpuop_pkg::DECREMENT_FILE_OPC: dec_o.kind = cpuop_pkg::OP_DECREMENT;
				cpuop_pkg::DEC_SKIP_ZERO_OPC: dec_o.kind = cpuop_pkg::OP_DEC_SKIP;
				cpuop_pkg::INC_SKIP_ZERO_OPC: dec_o.kind = cpuop_pkg::OP_INC_SKIP;
				default: dec_o.kind = cpuop_pkg::OP_NONE;
			endcase
		end
	end
endmodule // cpuop_decode
`default_nettype wire

// *** design/cpuop_core.sv ***
// execution core for subroutine call and unary file-register operations
// Function
// - a call first pushes program_counter plus one onto the stack top.
// - a call loads its 11-bit target into program_counter bits 10 to 0.
// - a call fills program_counter bits 12 and 11 from page_latch_register bits 4 and 3.
// - a call takes two instruction cycles and leaves every status flag unchanged.
// - complement inverts the file value, routes it by the destination bit and updates zero.
// - clear-file writes 00h to the file register and sets zero.
// - decrement subtracts one, routes the result by the destination bit and updates zero.
// - clear-working loads 00h into the working register and sets zero.
// - decrement-and-skip subtracts one, routes by destination, flags untouched.
// - a zero decrement-and-skip result turns the next instruction into a no_operation.
// - increment-and-skip adds one, routes by destination, flags untouched.
// - a zero increment-and-skip result turns the next instruction into a no_operation.
`default_nettype none
module cpuop_core
(
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// program memory
	output logic [cpuop_pkg::PC_W-1:0] program_counter_o,
	input wire logic [cpuop_pkg::INSN_W-1:0] insn_i,
	// page latch register value
	input wire logic [cpuop_pkg::LATCH_W-1:0] page_latch_register_i,
	// hardware stack
	output cpuop_pkg::cpuop_push_s push_o,
	// data register file
	output logic [cpuop_pkg::FADDR_W-1:0] file_raddr_o,
	input wire logic [cpuop_pkg::DATA_W-1:0] file_rdata_i,
	output cpuop_pkg::cpuop_fwr_s file_wr_o,
	// core state
	output logic [cpuop_pkg::DATA_W-1:0] working_o,
	output logic zero_flag_o,
	output logic busy_o
);
	typedef enum logic [1:0]
	{
		ST_EXEC,
		ST_CALL2,
		ST_SKIP
	} cpuop_state_e;

	cpuop_pkg::cpuop_dec_s dec;
	cpuop_state_e state_r;
	cpuop_state_e state_nxt;
	logic [cpuop_pkg::PC_W-1:0] pc_r;
	logic [cpuop_pkg::PC_W-1:0] pc_nxt;
	logic [cpuop_pkg::DATA_W-1:0] w_r;
	logic [cpuop_pkg::DATA_W-1:0] w_nxt;
	logic z_r;
	logic z_nxt;
	cpuop_pkg::cpuop_fwr_s fwr_r;
	cpuop_pkg::cpuop_fwr_s fwr_nxt;
	cpuop_pkg::cpuop_push_s push_r;
	cpuop_pkg::cpuop_push_s push_nxt;
	logic [cpuop_pkg::DATA_W-1:0] result;
	logic [cpuop_pkg::PC_W-1:0] pc_inc;

	cpuop_decode u_decode
	(
		.insn_i(insn_i),
		.dec_o(dec)
	);

	// helper decode of the word on insn_i and of state_r
	logic exec_now;
	logic routed_op;
	logic skip_op;
	logic skip_taken;

	assign pc_inc = pc_r + cpuop_pkg::PC_STEP;

	// a flush cycle (second call cycle or skipped word) executes nothing
	assign exec_now = (state_r == ST_EXEC);

	// operations whose result goes to W or back to the file by the destination bit
	assign routed_op = (dec.kind == cpuop_pkg::OP_COMPLEMENT) ||
		(dec.kind == cpuop_pkg::OP_DECREMENT) ||
		(dec.kind == cpuop_pkg::OP_DEC_SKIP) ||
		(dec.kind == cpuop_pkg::OP_INC_SKIP);

	assign skip_op = (dec.kind == cpuop_pkg::OP_DEC_SKIP) ||
		(dec.kind == cpuop_pkg::OP_INC_SKIP);

	// the skip decision uses the very result that is written back
	assign skip_taken = skip_op && (result == cpuop_pkg::ZERO_BYTE);

	// unary arithmetic, shared by the routed operations
	always_comb
	begin
		result = cpuop_pkg::ZERO_BYTE;
		case (dec.kind)
			cpuop_pkg::OP_COMPLEMENT:
			begin
				result = ~file_rdata_i;
			end
			cpuop_pkg::OP_DECREMENT:
			begin
				result = file_rdata_i - cpuop_pkg::ONE_BYTE;
			end
			cpuop_pkg::OP_DEC_SKIP:
			begin
				result = file_rdata_i - cpuop_pkg::ONE_BYTE;
			end
			cpuop_pkg::OP_INC_SKIP:
			begin
				result = file_rdata_i + cpuop_pkg::ONE_BYTE;
			end
			default:
			begin
				result = cpuop_pkg::ZERO_BYTE;
			end
		endcase
	end

	// sequencing: state and program_counter
	always_comb
	begin
		state_nxt = state_r;
		pc_nxt = pc_r;
		case (state_r)
			ST_EXEC:
			begin
				pc_nxt = pc_inc;
				if (dec.kind == cpuop_pkg::OP_CALL)
				begin
					pc_nxt = {page_latch_register_i[cpuop_pkg::PAGE_HI:cpuop_pkg::PAGE_LO],
						dec.target};
					state_nxt = ST_CALL2;
				end
				else if (skip_taken)
				begin
					state_nxt = ST_SKIP;
				end
			end
			ST_CALL2:
			begin
				// the word shown now is the target itself: discard it here but hold
				// the counter, so that it is fetched again and executed next cycle
				pc_nxt = pc_r;
				state_nxt = ST_EXEC;
			end
			ST_SKIP:
			begin
				// the word here is executed as a no_operation
				pc_nxt = pc_inc;
				state_nxt = ST_EXEC;
			end
			default:
			begin
				state_nxt = ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_r <= ST_EXEC;
			pc_r <= cpuop_pkg::PC_RESET;
		end
		else if (ce_i)
		begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
		end
	end

	// working register and zero flag
	// call and both skip operations fall to the default and leave the flag alone
	always_comb
	begin
		w_nxt = w_r;
		z_nxt = z_r;
		if (exec_now)
		begin
			case (dec.kind)
				cpuop_pkg::OP_COMPLEMENT:
				begin
					z_nxt = (result == cpuop_pkg::ZERO_BYTE);
				end
				cpuop_pkg::OP_DECREMENT:
				begin
					z_nxt = (result == cpuop_pkg::ZERO_BYTE);
				end
				cpuop_pkg::OP_CLEAR_FILE:
				begin
					z_nxt = 1'b1;
				end
				cpuop_pkg::OP_CLEAR_WORKING:
				begin
					w_nxt = cpuop_pkg::ZERO_BYTE;
					z_nxt = 1'b1;
				end
				default:
				begin
					z_nxt = z_r;
				end
			endcase
			if (routed_op && !dec.dest_file)
			begin
				w_nxt = result;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			w_r <= cpuop_pkg::ZERO_BYTE;
			z_r <= 1'b0;
		end
		else if (ce_i)
		begin
			w_r <= w_nxt;
			z_r <= z_nxt;
		end
	end

	// file register write request, registered one cycle after execute
	// while ce_i is low the strobe is held with the same address and data,
	// so the file sees the same value again and nothing changes
	always_comb
	begin
		fwr_nxt = '0;
		if (exec_now && dec.kind == cpuop_pkg::OP_CLEAR_FILE)
		begin
			fwr_nxt.en = 1'b1;
			fwr_nxt.addr = dec.faddr;
			fwr_nxt.data = cpuop_pkg::ZERO_BYTE;
		end
		else if (exec_now && routed_op && dec.dest_file)
		begin
			fwr_nxt.en = 1'b1;
			fwr_nxt.addr = dec.faddr;
			fwr_nxt.data = result;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			fwr_r <= '0;
		end
		else if (ce_i)
		begin
			fwr_r <= fwr_nxt;
		end
	end

	// stack push: the return address is the word after the call
	// the stack itself lies outside; only the request is made here
	always_comb
	begin
		push_nxt = '0;
		if (exec_now && dec.kind == cpuop_pkg::OP_CALL)
		begin
			push_nxt.en = 1'b1;
			push_nxt.addr = pc_inc;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			push_r <= '0;
		end
		else if (ce_i)
		begin
			push_r <= push_nxt;
		end
	end

	// file read address is combinational from the current word so the
	// operand is available within the same instruction cycle
	assign file_raddr_o = dec.faddr;
	assign program_counter_o = pc_r;
	assign working_o = w_r;
	assign zero_flag_o = z_r;
	assign file_wr_o = fwr_r;
	assign push_o = push_r;
	// busy marks the cycle whose word is thrown away
	assign busy_o = (state_r != ST_EXEC);
endmodule // cpuop_core
`default_nettype wire

// *** verif/cpuop_checker.sv ***
// checker: call, skip and unary-op behaviour at the core ports
`default_nettype none
module cpuop_checker
(
	// core ports
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [12:0] program_counter_o,
	input wire logic [13:0] insn_i,
	input wire logic [7:0] page_latch_register_i,
	input wire cpuop_pkg::cpuop_push_s push_o,
	input wire logic [6:0] file_raddr_o,
	input wire logic [7:0] file_rdata_i,
	input wire cpuop_pkg::cpuop_fwr_s file_wr_o,
	input wire logic [7:0] working_o,
	input wire logic zero_flag_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);
	logic ex;
	assign ex = ce_i & ~busy_o;
	sequence s_call;
		ex && insn_i[13:11] == 3'h4;
	endsequence
	a_call_push:
		assert property (s_call |=> push_o.en
			&& push_o.addr == $past(program_counter_o) + 13'h0001) else $error("bad push");
	a_call_target:
		assert property (s_call |=> program_counter_o
			== {$past(page_latch_register_i[4:3]), $past(insn_i[10:0])}) else $error("bad target");
	a_call_flags:
		assert property (s_call |=> busy_o && $stable(zero_flag_o)) else $error("bad call");
	a_busy_once:
		assert property (busy_o && ce_i |=> !busy_o) else $error("long busy");
	a_clear_file:
		assert property (ex && insn_i[13:7] == 7'h03 |=> file_wr_o.en && zero_flag_o
			&& file_wr_o.addr == $past(insn_i[6:0]) && file_wr_o.data == 8'h00) else $error("clr");
	a_comp_work:
		assert property (ex && insn_i[13:7] == 7'h12 |=> working_o == ~$past(file_rdata_i)
			&& zero_flag_o == (working_o == 8'h00)) else $error("bad complement");
	a_dec_file:
		assert property (ex && insn_i[13:7] == 7'h07 |=> file_wr_o.data
			== $past(file_rdata_i) - 8'h01) else $error("bad decrement");
	a_skip_zero:
		assert property (ex && ((insn_i[13:8] == 6'h0B && file_rdata_i == 8'h01)
			|| (insn_i[13:8] == 6'h0F && file_rdata_i == 8'hFF))
			|=> busy_o && $stable(zero_flag_o)) else $error("no skip");
	a_one_step:
		assert property (ex && (insn_i[13:8] == 6'h09 || insn_i[13:8] == 6'h03
			|| insn_i[13:8] == 6'h01) |=> !busy_o
			&& program_counter_o == $past(program_counter_o) + 13'h0001) else $error("step");
	a_call_hold:
		assert property (s_call ##1 (busy_o && ce_i) |=> !busy_o
			&& $stable(program_counter_o)) else $error("call target lost");
endmodule // cpuop_checker
bind cpuop_core cpuop_checker u_chk (.clk_sys_i, .rst_b_i, .ce_i, .program_counter_o,
	.insn_i, .page_latch_register_i, .push_o, .file_raddr_o, .file_rdata_i, .file_wr_o,
	.working_o, .zero_flag_o, .busy_o);
`default_nettype wire

// *** verif/cpuop_mem.sv ***
// partner: program memory and data register file
`default_nettype none
module cpuop_mem
(
	// core side
	input wire logic clk_sys_i,
	input wire logic [12:0] pc_i,
	output logic [13:0] insn_o,
	input wire logic [6:0] raddr_i,
	output logic [7:0] rdata_o,
	input wire cpuop_pkg::cpuop_fwr_s wr_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [13:0] prog [0:63];
	logic [7:0] file [0:127];
	// small memory: fetch wraps on the low address bits
	assign insn_o = prog[pc_i[5:0]];
	assign rdata_o = file[raddr_i];
	always @(posedge clk_sys_i)
		if (wr_i.en)
			file[wr_i.addr] <= wr_i.data;
endmodule // cpuop_mem
`default_nettype wire

// *** verif/tb_cpu_call_and_unary_ops.sv ***
// testbench: short program through the core, checks file writes, pushes and W
`default_nettype none
module tb_cpu_call_and_unary_ops;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic ce_i = 1'b0;
	logic [7:0] page_latch_register_i = 8'h00;
	logic [12:0] program_counter_o;
	logic [13:0] insn_i;
	logic [6:0] file_raddr_o;
	logic [7:0] file_rdata_i, working_o, v, w_exp;
	logic zero_flag_o, busy_o;
	cpuop_pkg::cpuop_push_s push_o;
	cpuop_pkg::cpuop_fwr_s file_wr_o;
	logic [15:0] exp_q [$];
	int failures = 0;
	int num_checks = 0;
	logic ce_seen = 1'b0;
	// outputs only change at an enabled edge; a frozen cycle shows the old strobe
	always @(posedge clk_sys_i)
		ce_seen <= ce_i;
	always #50 clk_sys_i = ~clk_sys_i;
	cpuop_core u_dut (.clk_sys_i, .rst_b_i, .ce_i, .program_counter_o, .insn_i,
		.page_latch_register_i, .push_o, .file_raddr_o, .file_rdata_i, .file_wr_o,
		.working_o, .zero_flag_o, .busy_o);
	cpuop_mem u_mem (.clk_sys_i, .pc_i(program_counter_o), .insn_o(insn_i),
		.raddr_i(file_raddr_o), .rdata_o(file_rdata_i), .wr_i(file_wr_o));
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want)
		begin
			failures++;
			$display("ERROR %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// preload a file register and note the write that should follow
	task automatic wf(input logic [6:0] f, input logic [7:0] d, input logic [7:0] e);
		u_mem.file[f] = d;
		exp_q.push_back({1'b1, f, e});
		v = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endtask
	always @(negedge clk_sys_i)
	begin
		if (ce_seen && file_wr_o.en === 1'b1)
			check(file_wr_o, exp_q.pop_front());
		if (ce_seen && push_o.en === 1'b1)
			check({2'h0, push_o}, exp_q.pop_front());
	end
	initial
	begin
		#20000;
		failures++;
		report_and_stop();
	end
	initial
	begin
		v = 8'h46;
		for (int i = 0; i < 64; i++)
			u_mem.prog[i] = 14'h0000;
		u_mem.prog[0] = {6'h09, 8'h8A};
		u_mem.prog[1] = {6'h03, 8'h8B};
		u_mem.prog[2] = {7'h03, 7'h0C};
		u_mem.prog[3] = {6'h0B, 8'h8D};
		u_mem.prog[4] = {7'h03, 7'h0E};
		u_mem.prog[5] = {6'h0F, 8'h8F};
		u_mem.prog[6] = {7'h03, 7'h0E};
		u_mem.prog[7] = {6'h0F, 8'h90};
		u_mem.prog[8] = {6'h0B, 8'h11};
		u_mem.prog[9] = {7'h02, 7'h00};
		u_mem.prog[10] = {6'h09, 8'h0A};
		u_mem.prog[11] = {3'h4, 11'h414};
		u_mem.prog[20] = {7'h03, 7'h0E};
		u_mem.prog[21] = {7'h03, 7'h12};
		u_mem.prog[22] = {6'h03, 8'h93};
		w_exp = v;
		wf(7'h0A, v, ~v);
		wf(7'h0B, v, v - 8'h01);
		wf(7'h0C, v, 8'h00);
		wf(7'h0D, 8'h01, 8'h00);
		wf(7'h0F, 8'hFF, 8'h00);
		wf(7'h10, v & 8'hFE, (v & 8'hFE) + 8'h01);
		u_mem.file[17] = v | 8'h80;
		exp_q.push_back(16'h200C);
		wf(7'h0E, v, 8'h00);
		wf(7'h12, v, 8'h00);
		wf(7'h13, 8'h00, 8'hFF);
		repeat (2) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		for (int n = 0; n < 80 && exp_q.size() > 0; n++)
		begin
			v = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
			ce_i = v[0] | v[1];
			page_latch_register_i = v;
			@(negedge clk_sys_i);
		end
		ce_i = 1'b0;
		check(16'(exp_q.size()), 16'h0000);
		check({8'h00, working_o}, {8'h00, w_exp});
		check({15'h0000, zero_flag_o}, 16'h0000);
		report_and_stop();
	end
endmodule // tb_cpu_call_and_unary_ops
`default_nettype wire
